/* common/ddu_defines.svh */
// constants for the decode and dispatch unit: modR/M fields, latencies, register indices
`ifndef DDU_DEFINES_SVH
`define DDU_DEFINES_SVH
`define DDU_MODE_HI 7
`define DDU_MODE_LO 6
`define DDU_MODE_REG 2'h3
`define DDU_REG_HI 5
`define DDU_REG_LO 3
`define DDU_RM_HI 2
`define DDU_RM_LO 0
`define DDU_MEDIA_BASE 5'h08
`define DDU_TEMP_REG 5'h10
`define DDU_NREG 32
`define DDU_LAT_ALU 2'h1
`define DDU_LAT_MUL 2'h2
`define DDU_LAT_MUL_STALL 2'h3
`define DDU_LAT_LOAD 2'h3
`define DDU_CHAIN_LOAD 3'h2
`define DDU_CHAIN_STORE 3'h1
`define DDU_WIN_DEFAULT 4
`endif

/* common/ddu_pkg.sv */
// types shared by the decode and dispatch unit and its bench
package ddu_pkg;
  typedef enum logic [1:0] {DDU_SHORT, DDU_LONG, DDU_VECTOR} ddu_class_e;
  typedef enum logic [2:0] {
    DDU_K_INT, DDU_K_MEDIA, DDU_K_MMUL, DDU_K_EMPTY, DDU_K_FEMPTY,
    DDU_K_BRANCH, DDU_K_FLOAT, DDU_K_LIMM
  } ddu_kind_e;
  typedef enum logic [2:0] {
    DDU_U_LOAD, DDU_U_STORE, DDU_U_X, DDU_U_XY, DDU_U_BRANCH, DDU_U_FLOAT,
    DDU_U_CTRL, DDU_U_VEC
  } ddu_unit_e;
  typedef logic [4:0] ddu_reg_t;
  typedef struct packed {
    logic valid;
    ddu_class_e cls;
    ddu_kind_e kind;
    logic has_load;
    logic has_store;
    logic x_only;
    logic reg_in_opc;
    logic split;
    logic [2:0] opc_reg;
    logic [7:0] modrm;
  } ddu_instr_s;
  typedef struct packed {
    logic [7:0] units;
    logic [2:0] lat;
  } ddu_chain_s;
  typedef struct packed {
    logic valid;
    ddu_class_e cls;
    logic mem_form;
    ddu_reg_t first;
    ddu_reg_t second;
    ddu_chain_s c0;
    ddu_chain_s c1;
  } ddu_trans_s;
  typedef struct packed {
    logic valid;
    ddu_reg_t dest;
    logic mul;
    logic stall_e1;
  } ddu_exec_s;
  typedef struct packed {
    logic valid;
    logic busy;
    logic x_only;
    logic mul;
    ddu_reg_t dst;
    ddu_reg_t sa;
    ddu_reg_t sb;
  } ddu_rop_s;
  typedef struct packed {
    logic rop;
    logic ld;
    logic st;
    logic xo;
    logic mul;
    logic br;
    logic fp;
    logic limm;
    ddu_class_e cls;
    ddu_reg_t dst;
    ddu_reg_t sb;
    ddu_reg_t ld_dst;
    ddu_trans_s tr;
  } ddu_dec_s;
endpackage : ddu_pkg

/* design/ddu_decode_dispatch.sv */
// decode, issue window, operand fetch and dispatch for two register units
`timescale 1ns/100ps
`include "ddu_defines.svh"
module ddu_decode_dispatch import ddu_pkg::*; #(
  parameter int WIN = `DDU_WIN_DEFAULT
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // fetch side
  input wire ddu_instr_s FETCH_SLOT0,
  input wire ddu_instr_s FETCH_SLOT1,
  output logic [1:0] DECODE_TAKE,
  // translation records
  output ddu_trans_s TRANS0,
  output ddu_trans_s TRANS1,
  // execution units
  output ddu_exec_s LOAD_EXEC,
  output ddu_exec_s EXEC_X,
  output ddu_exec_s EXEC_Y,
  output ddu_exec_s STQ_ALLOC,
  output logic BRANCH_GO,
  output logic FLOAT_GO,
  output logic LIMM_DONE
);
  localparam int IW = (WIN > 1) ? $clog2(WIN) : 1;

  initial begin
    if (WIN < 2 || WIN > 16) begin
      $error("WIN must lie in 2..16");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction classification and operand extraction
  function automatic ddu_dec_s decode(input ddu_instr_s i);
    ddu_dec_s d;
    logic med;
    logic mem;
    ddu_reg_t base;
    d = '0;
    med = (i.kind == DDU_K_MEDIA) || (i.kind == DDU_K_MMUL);
    base = med ? `DDU_MEDIA_BASE : 5'h00;
    mem = i.modrm[`DDU_MODE_HI:`DDU_MODE_LO] != `DDU_MODE_REG;
    if (med) begin
      d.cls = DDU_SHORT;
    end else if (i.kind == DDU_K_EMPTY || i.kind == DDU_K_FEMPTY) begin
      d.cls = DDU_VECTOR;
    end else begin
      d.cls = i.cls;
    end
    d.rop = med || (i.kind == DDU_K_INT);
    d.mul = i.kind == DDU_K_MMUL;
    d.xo = i.x_only && (i.kind == DDU_K_INT);
    d.ld = i.has_load && mem;
    d.st = i.has_store && mem;
    d.br = i.kind == DDU_K_BRANCH;
    d.fp = i.kind == DDU_K_FLOAT;
    d.limm = i.kind == DDU_K_LIMM;
    if (i.reg_in_opc && !med) begin
      d.dst = {2'h0, i.opc_reg};
    end else begin
      d.dst = base | {2'h0, i.modrm[`DDU_REG_HI:`DDU_REG_LO]};
    end
    // memory form reads the loaded value from the temporary register
    d.sb = mem ? `DDU_TEMP_REG : (base | {2'h0, i.modrm[`DDU_RM_HI:`DDU_RM_LO]});
    d.ld_dst = d.rop ? `DDU_TEMP_REG : d.dst;
    d.tr.valid = i.valid;
    d.tr.cls = d.cls;
    d.tr.mem_form = mem;
    d.tr.first = d.dst;
    d.tr.second = d.sb;
    if (d.ld) begin
      d.tr.c0.units[DDU_U_LOAD] = 1'b1;
      d.tr.c0.lat = `DDU_CHAIN_LOAD;
    end
    if (d.rop) begin
      d.tr.c0.units[d.xo ? DDU_U_X : DDU_U_XY] = 1'b1;
      d.tr.c0.lat = d.tr.c0.lat + {1'b0, d.mul ? `DDU_LAT_MUL : `DDU_LAT_ALU};
    end
    d.tr.c0.units[DDU_U_BRANCH] = d.br;
    d.tr.c0.units[DDU_U_FLOAT] = d.fp;
    d.tr.c0.units[DDU_U_CTRL] = d.limm;
    d.tr.c0.units[DDU_U_VEC] = d.cls == DDU_VECTOR;
    if (d.st && i.split) begin
      d.tr.c1.units[DDU_U_STORE] = 1'b1;
      d.tr.c1.lat = `DDU_CHAIN_STORE;
    end else if (d.st) begin
      d.tr.c0.units[DDU_U_STORE] = 1'b1;
      d.tr.c0.lat = d.tr.c0.lat + `DDU_CHAIN_STORE;
    end
    return d;
  endfunction : decode

  ddu_dec_s d0;
  ddu_dec_s d1;
  assign d0 = decode(FETCH_SLOT0);
  assign d1 = decode(FETCH_SLOT1);

  ////////////////////////////////////////////////////////////////////////////
  // state
  ddu_rop_s win_q [WIN];
  logic [`DDU_NREG-1:0] pend_q;
  logic [1:0] cnt_q [`DDU_NREG];
  logic ofx_v_q;
  logic ofy_v_q;
  logic [IW-1:0] ofx_i_q;
  logic [IW-1:0] ofy_i_q;
  ddu_exec_s ld_i_q;
  ddu_exec_s st_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode acceptance
  logic [IW-1:0] f0;
  logic [IW-1:0] f1;
  logic h0;
  logic h1;
  always_comb begin
    f0 = '0;
    f1 = '0;
    h0 = 1'b0;
    h1 = 1'b0;
    for (int i = 0; i < WIN; i++) begin
      if (!win_q[i].valid && !h0) begin
        f0 = IW'(i);
        h0 = 1'b1;
      end else if (!win_q[i].valid && !h1) begin
        f1 = IW'(i);
        h1 = 1'b1;
      end
    end
  end

  logic take0;
  logic take1;
  assign take0 = FETCH_SLOT0.valid && (!d0.rop || h0) && (!d0.st || !st_q.valid);
  // pairing only between two short decodes, never across classes
  assign take1 = take0 && FETCH_SLOT1.valid && d0.cls == DDU_SHORT && d1.cls == DDU_SHORT
    && !(d0.ld && d1.ld) && !(d1.st && (d0.st || st_q.valid))
    && (!d1.rop || (d0.rop ? h1 : h0));
  assign DECODE_TAKE = {take1, take0};

  logic a0;
  logic a1;
  logic [IW-1:0] a1_idx;
  assign a0 = take0 && d0.rop;
  assign a1 = take1 && d1.rop;
  assign a1_idx = a0 ? f1 : f0;

  ////////////////////////////////////////////////////////////////////////////
  // issue selection: lowest-numbered slot first, at most two per cycle
  logic sx_v;
  logic sy_v;
  logic [IW-1:0] sx_i;
  logic [IW-1:0] sy_i;
  always_comb begin
    sx_v = 1'b0;
    sy_v = 1'b0;
    sx_i = '0;
    sy_i = '0;
    for (int i = 0; i < WIN; i++) begin
      // bumped entries rejoin as ordinary candidates, picked by slot number alone; readiness is not checked here
      if (win_q[i].valid && !win_q[i].busy) begin
        if (win_q[i].x_only) begin
          if (!sx_v) begin
            sx_v = 1'b1;
            sx_i = IW'(i);
          end
        end else if (!sx_v) begin
          sx_v = 1'b1;
          sx_i = IW'(i);
        end else if (!sy_v) begin
          sy_v = 1'b1;
          sy_i = IW'(i);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand fetch check
  logic [`DDU_NREG-1:0] rdy;
  always_comb begin
    for (int r = 0; r < `DDU_NREG; r++) begin
      rdy[r] = !pend_q[r] && cnt_q[r] <= 2'h1;
    end
  end

  ddu_rop_s ox;
  ddu_rop_s oy;
  logic acc_x;
  logic acc_y;
  logic both_mul;
  assign ox = win_q[ofx_i_q];
  assign oy = win_q[ofy_i_q];
  // an op's own pend bit must not block it when it also reads its destination
  assign acc_x = ofx_v_q
    && (rdy[ox.sa] || (ox.sa == ox.dst && cnt_q[ox.sa] <= 2'h1))
    && (rdy[ox.sb] || (ox.sb == ox.dst && cnt_q[ox.sb] <= 2'h1));
  // the Y op never takes a result that X produces in the same cycle
  assign acc_y = ofy_v_q
    && (rdy[oy.sa] || (oy.sa == oy.dst && cnt_q[oy.sa] <= 2'h1))
    && (rdy[oy.sb] || (oy.sb == oy.dst && cnt_q[oy.sb] <= 2'h1))
    && !(acc_x && (ox.dst == oy.sa || ox.dst == oy.sb));
  assign both_mul = acc_x && acc_y && ox.mul && oy.mul;

  ////////////////////////////////////////////////////////////////////////////
  // window entries
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < WIN; i++) begin
        win_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < WIN; i++) begin
        if (a0 && f0 == IW'(i)) begin
          win_q[i] <= '{1'b1, 1'b0, d0.xo, d0.mul, d0.dst, d0.dst, d0.sb};
        end else if (a1 && a1_idx == IW'(i)) begin
          win_q[i] <= '{1'b1, 1'b0, d1.xo, d1.mul, d1.dst, d1.dst, d1.sb};
        end else if ((acc_x && ofx_i_q == IW'(i)) || (acc_y && ofy_i_q == IW'(i))) begin
          win_q[i].valid <= 1'b0;
        end else if ((ofx_v_q && ofx_i_q == IW'(i)) || (ofy_v_q && ofy_i_q == IW'(i))) begin
          win_q[i].busy <= 1'b0;
        end else if ((sx_v && sx_i == IW'(i)) || (sy_v && sy_i == IW'(i))) begin
          win_q[i].busy <= 1'b1;
        end
      end
    end
  end

  // issue to operand fetch, one clock per stage
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ofx_v_q <= 1'b0;
      ofy_v_q <= 1'b0;
      ofx_i_q <= '0;
      ofy_i_q <= '0;
    end else begin
      ofx_v_q <= sx_v;
      ofy_v_q <= sy_v;
      ofx_i_q <= sx_i;
      ofy_i_q <= sy_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scoreboard: pending writers and cycles until bypass
  // limitation: two in-flight writers of one register share a single pend bit
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q <= '0;
    end else begin
      for (int r = 0; r < `DDU_NREG; r++) begin
        if ((a0 && d0.dst == 5'(r)) || (a1 && d1.dst == 5'(r))
            || (take0 && d0.ld && d0.ld_dst == 5'(r))
            || (take1 && d1.ld && d1.ld_dst == 5'(r))) begin
          pend_q[r] <= 1'b1;
        end else if ((acc_x && ox.dst == 5'(r)) || (acc_y && oy.dst == 5'(r))
                     || (ld_i_q.valid && ld_i_q.dest == 5'(r))) begin
          pend_q[r] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int r = 0; r < `DDU_NREG; r++) begin
        cnt_q[r] <= 2'h0;
      end
    end else begin
      for (int r = 0; r < `DDU_NREG; r++) begin
        if (acc_y && oy.dst == 5'(r)) begin
          cnt_q[r] <= !oy.mul ? `DDU_LAT_ALU : (both_mul ? `DDU_LAT_MUL_STALL : `DDU_LAT_MUL);
        end else if (acc_x && ox.dst == 5'(r)) begin
          cnt_q[r] <= ox.mul ? `DDU_LAT_MUL : `DDU_LAT_ALU;
        end else if (ld_i_q.valid && ld_i_q.dest == 5'(r)) begin
          cnt_q[r] <= `DDU_LAT_LOAD;
        end else if (cnt_q[r] != 2'h0) begin
          cnt_q[r] <= cnt_q[r] - 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register unit results
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      EXEC_X <= '0;
      EXEC_Y <= '0;
    end else begin
      EXEC_X <= '{acc_x, ox.dst, ox.mul, 1'b0};
      EXEC_Y <= '{acc_y, oy.dst, oy.mul, both_mul};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // load unit path: issue then operand fetch, one load per clock
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ld_i_q <= '0;
      LOAD_EXEC <= '0;
    end else begin
      if (take0 && d0.ld) begin
        ld_i_q <= '{1'b1, d0.ld_dst, 1'b0, 1'b0};
      end else if (take1 && d1.ld) begin
        ld_i_q <= '{1'b1, d1.ld_dst, 1'b0, 1'b0};
      end else begin
        ld_i_q <= '0;
      end
      LOAD_EXEC <= ld_i_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // store unit: completion held until the data register is bypassable
  logic st_done;
  assign st_done = st_q.valid && rdy[st_q.dest];
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= '0;
      STQ_ALLOC <= '0;
    end else begin
      if (take0 && d0.st) begin
        st_q <= '{1'b1, d0.dst, d0.mul, 1'b0};
      end else if (take1 && d1.st) begin
        st_q <= '{1'b1, d1.dst, d1.mul, 1'b0};
      end else if (st_done) begin
        st_q <= '0;
      end
      // data goes straight into a freshly allocated queue entry
      STQ_ALLOC <= st_done ? st_q : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // other dispatch and translation records
  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      BRANCH_GO <= 1'b0;
      FLOAT_GO <= 1'b0;
      LIMM_DONE <= 1'b0;
    end else begin
      BRANCH_GO <= (take0 && d0.br) || (take1 && d1.br);
      FLOAT_GO <= (take0 && d0.fp) || (take1 && d1.fp);
      // load-immediate finishes in control, no unit is occupied
      LIMM_DONE <= (take0 && d0.limm) || (take1 && d1.limm);
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      TRANS0 <= '0;
      TRANS1 <= '0;
    end else begin
      TRANS0 <= take0 ? d0.tr : '0;
      TRANS1 <= take1 ? d1.tr : '0;
    end
  end

endmodule : ddu_decode_dispatch

/* tb/ddu_decode_dispatch_sva.sv */
// checker for decode, translation and dispatch timing at the unit's ports
`timescale 1ns/100ps
module ddu_decode_dispatch_sva import ddu_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // fetch side
  input wire ddu_instr_s FETCH_SLOT0,
  input wire ddu_instr_s FETCH_SLOT1,
  input wire logic [1:0] DECODE_TAKE,
  // results
  input wire ddu_trans_s TRANS0,
  input wire logic BRANCH_GO,
  input wire logic LIMM_DONE
);
  logic tk0;
  logic tk1;
  assign tk0 = DECODE_TAKE[0] && FETCH_SLOT0.valid;
  assign tk1 = DECODE_TAKE[1] && FETCH_SLOT1.valid;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  //////////////////////////////////////////////////////////////////////////////
  take_order_a: assert property (DECODE_TAKE[1] |-> DECODE_TAKE[0])
    else $error("second slot taken without first");
  pair_class_a: assert property (tk1 |-> FETCH_SLOT0.cls == DDU_SHORT
    && FETCH_SLOT1.cls == DDU_SHORT && !(FETCH_SLOT1.kind inside {DDU_K_EMPTY, DDU_K_FEMPTY}))
    else $error("pair taken with a non-short instruction");
  trans_next_a: assert property (tk0 |=> TRANS0.valid)
    else $error("no translation record after take");
  mem_form_a: assert property (tk0 |=>
    TRANS0.mem_form == ($past(FETCH_SLOT0.modrm[7:6]) != 2'h3))
    else $error("wrong operand form");
  reg_sel_a: assert property (tk0 && FETCH_SLOT0.kind == DDU_K_INT &&
    !FETCH_SLOT0.reg_in_opc |=> TRANS0.first == {2'h0, $past(FETCH_SLOT0.modrm[5:3])})
    else $error("wrong general register selector");
  rm_sel_a: assert property (tk0 && FETCH_SLOT0.kind == DDU_K_INT &&
    FETCH_SLOT0.modrm[7:6] == 2'h3 |=> TRANS0.second == {2'h0, $past(FETCH_SLOT0.modrm[2:0])})
    else $error("wrong second register");
  media_sel_a: assert property (tk0 && FETCH_SLOT0.kind == DDU_K_MEDIA |=>
    TRANS0.first == {2'h1, $past(FETCH_SLOT0.modrm[5:3])} &&
    TRANS0.second == {2'h1, $past(FETCH_SLOT0.modrm[2:0])})
    else $error("wrong media registers");
  branch_go_a: assert property ((tk0 && FETCH_SLOT0.kind == DDU_K_BRANCH) ||
    (tk1 && FETCH_SLOT1.kind == DDU_K_BRANCH) |=> BRANCH_GO)
    else $error("branch not dispatched");
  limm_done_a: assert property ((tk0 && FETCH_SLOT0.kind == DDU_K_LIMM) ||
    (tk1 && FETCH_SLOT1.kind == DDU_K_LIMM) |=> LIMM_DONE)
    else $error("load immediate not completed");
  cover property (DECODE_TAKE == 2'h3);
  cover property (tk0 && FETCH_SLOT0.has_load);
  cover property (BRANCH_GO);
endmodule : ddu_decode_dispatch_sva
bind ddu_decode_dispatch ddu_decode_dispatch_sva u_sva (
  .CLK(CLK), .RST_N(RST_N), .FETCH_SLOT0(FETCH_SLOT0), .FETCH_SLOT1(FETCH_SLOT1),
  .DECODE_TAKE(DECODE_TAKE), .TRANS0(TRANS0), .BRANCH_GO(BRANCH_GO), .LIMM_DONE(LIMM_DONE)
);

/* tb/ddu_fetch_model.sv */
// fetch side model: holds offered instructions until the decoder takes them
`timescale 1ns/100ps
module ddu_fetch_model import ddu_pkg::*; (
  // clock and handshake
  input wire logic clk,
  input wire logic [1:0] take,
  // offered slots
  output ddu_instr_s slot0,
  output ddu_instr_s slot1
);
  logic [1:0] first_take;
  initial begin
    slot0 = '0;
    slot1 = '0;
    first_take = 2'h0;
  end
  // take sampled mid-cycle, so the edge's own updates never race it
  task automatic offer(input ddu_instr_s a, input ddu_instr_s b);
    logic [1:0] t;
    first_take = 2'h0;
    slot0 = a;
    slot1 = b;
    for (int n = 0; n < 40 && slot0.valid; n++) begin
      @(negedge clk);
      t = take;
      @(posedge clk);
      #1;
      if (first_take == 2'h0) begin
        first_take = t;
      end
      if (t[0] && t[1]) begin
        slot0 = '0;
        slot1 = '0;
      end else if (t[0]) begin
        slot0 = slot1;
        slot1 = '0;
      end
    end
  endtask : offer
endmodule : ddu_fetch_model

/* tb/tb.sv */
// self-checking bench for the decode and dispatch unit
`timescale 1ns/100ps
module tb import ddu_pkg::*;;
  logic clk;
  logic rst_n;
  ddu_instr_s s0;
  ddu_instr_s s1;
  logic [1:0] take;
  ddu_trans_s tr0;
  ddu_trans_s tr1;
  ddu_exec_s ld_e;
  ddu_exec_s ex_x;
  ddu_exec_s ex_y;
  ddu_exec_s st_a;
  logic br_go;
  logic fp_go;
  logic limm_dn;
  int err_count;
  int checks;
  int cycles;
  ddu_decode_dispatch #(.WIN(4)) u_dut (
    .CLK(clk), .RST_N(rst_n), .FETCH_SLOT0(s0), .FETCH_SLOT1(s1), .DECODE_TAKE(take),
    .TRANS0(tr0), .TRANS1(tr1), .LOAD_EXEC(ld_e), .EXEC_X(ex_x), .EXEC_Y(ex_y),
    .STQ_ALLOC(st_a), .BRANCH_GO(br_go), .FLOAT_GO(fp_go), .LIMM_DONE(limm_dn)
  );
  ddu_fetch_model u_fm (.clk(clk), .take(take), .slot0(s0), .slot1(s1));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  function automatic ddu_instr_s mk(ddu_kind_e k, ddu_class_e c, logic [7:0] m, logic ld);
    return '{1'h1, c, k, ld, 1'h0, 1'h0, 1'h0, 1'h0, 3'h0, m};
  endfunction : mk
  task automatic gap;
    repeat (8) @(posedge clk);
    #1;
  endtask : gap
  task automatic wrap_up;
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_pair;
    u_fm.offer(mk(DDU_K_INT, DDU_SHORT, 8'hCA, 1'h0), mk(DDU_K_INT, DDU_SHORT, 8'hDC, 1'h0));
    check("pair take", u_fm.first_take, 2'h3);
    check("trans1 valid", tr1.valid, 1'h1);
    repeat (2) @(posedge clk);
    #1;
    check("x dest", ex_x.dest, 5'h01);
    check("y valid", ex_y.valid, 1'h1);
    check("y dest", ex_y.dest, 5'h03);
  endtask : t_pair
  task automatic t_dep;
    // producer decoded one cycle before its dependant
    u_fm.offer(mk(DDU_K_INT, DDU_SHORT, 8'hCA, 1'h0), '0);
    u_fm.offer(mk(DDU_K_INT, DDU_SHORT, 8'hE9, 1'h0), '0);
    @(posedge clk);
    #1;
    check("producer", ex_x.dest, 5'h01);
    check("dependant early", ex_y.valid, 1'h0);
    @(posedge clk);
    #1;
    check("dependant", (ex_x.valid && ex_x.dest == 5'h05) ||
      (ex_y.valid && ex_y.dest == 5'h05), 1'h1);
  endtask : t_dep
  task automatic t_media;
    u_fm.offer(mk(DDU_K_MEDIA, DDU_SHORT, 8'hD6, 1'h0), mk(DDU_K_INT, DDU_SHORT, 8'hDD, 1'h0));
    check("media first", tr0.first, 5'h0A);
    check("media second", tr0.second, 5'h0E);
    check("reg first", tr1.first, 5'h03);
    check("reg second", tr1.second, 5'h05);
    check("reg form", tr1.mem_form, 1'h0);
  endtask : t_media
  task automatic t_classes;
    ddu_kind_e ek[2];
    ek = '{DDU_K_EMPTY, DDU_K_FEMPTY};
    u_fm.offer(mk(DDU_K_INT, DDU_LONG, 8'hCA, 1'h0), mk(DDU_K_INT, DDU_SHORT, 8'hDC, 1'h0));
    check("long alone", u_fm.first_take, 2'h1);
    for (int i = 0; i < 2; i++) begin
      gap();
      u_fm.offer(mk(DDU_K_INT, DDU_SHORT, 8'hC0, 1'h0), mk(ek[i], DDU_SHORT, 8'hC0, 1'h0));
      check("empty not paired", u_fm.first_take, 2'h1);
      check("empty class", tr0.cls, DDU_VECTOR);
    end
  endtask : t_classes
  task automatic t_load;
    logic [7:0] md[3];
    md = '{8'h0B, 8'h4B, 8'h8B};
    for (int i = 0; i < 3; i++) begin
      gap();
      u_fm.offer(mk(DDU_K_INT, DDU_SHORT, md[i], 1'h1), '0);
      check("memory form", tr0.mem_form, 1'h1);
      for (int n = 0; n < 6 && ld_e.valid !== 1'h1; n++) begin
        @(posedge clk);
        #1;
      end
      check("load unit", ld_e.valid, 1'h1);
      check("load dest", ld_e.dest, 5'h10);
    end
  endtask : t_load
  task automatic t_ctrl;
    ddu_kind_e ck[3];
    ck = '{DDU_K_BRANCH, DDU_K_FLOAT, DDU_K_LIMM};
    for (int i = 0; i < 3; i++) begin
      gap();
      u_fm.offer(mk(ck[i], DDU_SHORT, 8'hC0, 1'h0), '0);
      check("control units", {br_go, fp_go, limm_dn}, 3'h4 >> i);
    end
  endtask : t_ctrl
  task automatic t_mul;
    u_fm.offer(mk(DDU_K_MMUL, DDU_SHORT, 8'hC1, 1'h0), mk(DDU_K_MMUL, DDU_SHORT, 8'hD3, 1'h0));
    repeat (2) @(posedge clk);
    #1;
    check("x mul", {ex_x.valid, ex_x.mul}, 2'h3);
    check("y mul stall", {ex_y.valid, ex_y.mul, ex_y.stall_e1}, 3'h7);
  endtask : t_mul
  task automatic t_store;
    ddu_instr_s si;
    si = mk(DDU_K_INT, DDU_LONG, 8'h0B, 1'h1);
    si.has_store = 1'h1;
    u_fm.offer(si, '0);
    for (int n = 0; n < 12 && st_a.valid !== 1'h1; n++) begin
      @(posedge clk);
      #1;
    end
    check("store alloc", st_a.valid, 1'h1);
    check("store data reg", st_a.dest, 5'h01);
  endtask : t_store
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    err_count = 0;
    checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_pair();
    gap();
    t_dep();
    gap();
    t_media();
    gap();
    t_classes();
    t_load();
    t_ctrl();
    gap();
    t_mul();
    gap();
    t_store();
    wrap_up();
  end
endmodule : tb
